//--- design/spf_top.sv
// serial port framing, character length, select pin control and status flags
// assumes a register port with read data one cycle after the read strobe,
// and serial pins that are resolved from the enables outside this module
//
// Behaviour
// - SPI output select pin follows select_value
// - end_of_frame_flag clears select_value at frame end
// - SPI serial clock toggles only per bit
// - loopback master: outputs off, output looped in
// - loopback slave echoes MOSI onto MISO
// - I2S master select leads data one period
// - I2S clock runs, frames back to back
// - I2S slave starts on any select edge
// - char_length code sets bits per character
// - select_pin_direction chooses input or output
// - select_polarity chooses active low or high
// - disabled port returns flags to reset
// - tx_holding_empty set when empty, write clears
// - rx_holding_full set on character, read clears
// - error flags clear by writing one
// - early select deassert in slave sets abort
// - slave clock monitor timeout sets abort
// - mode fault sets multi_master_collision
// - underrun and overrun flags stay until cleared
// - transfer_active high during a transfer
// - select_level is pin xor polarity
`timescale 1ns/1ns
`default_nettype none
`include "spf_regs.svh"

module spf_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [23:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire spf_pkg::spf_pin_in_s pin_in,
  output var spf_pkg::spf_pin_out_s pin_out
);
  import spf_pkg::*;

  spf_state_s s;
  spf_state_s next_s;
  spf_pin_in_s syn;
  logic tick;
  logic [3:0] len;
  logic [7:0] txalign;
  logic [7:0] rmask;
  logic [7:0] shifted;
  logic [7:0] flags_rd;
  logic is_spi;
  logic is_loop;
  logic is_i2s;
  logic ss_act;
  logic sck_rise;
  logic sck_fall;
  logic ss_edge;
  logic sin;
  logic mo_en;

  // bits per character; 011 has no printed length and is taken as five
  function automatic logic [3:0] char_len(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h8;
    unique case (code)
      3'h0: n = 4'h8;
      3'h1: n = 4'h1;
      3'h2: n = 4'h2;
      3'h3: n = 4'h5;
      3'h4: n = 4'h4;
      3'h5: n = 4'h3;
      3'h6: n = 4'h6;
      3'h7: n = 4'h7;
    endcase
    return n;
  endfunction : char_len

  // pin level for a select_value under the current polarity
  function automatic logic sel_pin(input logic v, input logic pol);
    return pol ? v : ~v;
  endfunction : sel_pin

  spf_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .raw(pin_in),
    .synced(syn)
  );

  spf_ticker u_ticker (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(s.en && s.mst && (s.fsm != SPF_IDLE)),
    .tick(tick)
  );

  // decoded configuration and pin events
  assign len = char_len(s.cfg[`SPF_CFG_LEN_MSB:`SPF_CFG_LEN_LSB]);
  assign txalign = s.txd << (4'h8 - len);
  assign rmask = 8'hff >> (4'h8 - len);
  assign shifted = {s.shreg[6:0], s.samp};
  assign is_spi = (s.cfg[`SPF_CFG_FRAME_MSB:`SPF_CFG_FRAME_LSB] == SPF_FR_SPI);
  assign is_loop = (s.cfg[`SPF_CFG_FRAME_MSB:`SPF_CFG_FRAME_LSB] == SPF_FR_LOOP);
  assign is_i2s = (s.cfg[`SPF_CFG_FRAME_MSB:`SPF_CFG_FRAME_LSB] == SPF_FR_I2S);
  assign ss_act = (syn.ss == s.cfg[`SPF_CFG_POL]);
  assign sck_rise = syn.sck & ~s.sck_prev;
  assign sck_fall = ~syn.sck & s.sck_prev;
  assign ss_edge = syn.ss ^ s.ss_prev;
  // loopback master feeds its own output bit back in
  assign sin = (is_loop && s.mst) ? s.shreg[7] : (s.mst ? syn.miso : syn.mosi);
  assign mo_en = s.en && s.mst && !is_loop;
  assign flags_rd = {s.en && !s.tx_full, s.tx_underrun, s.col, s.slave_abort, s.rx_overrun, s.rx_holding_full,
                     s.fsm != SPF_IDLE, s.select_level};

  always_comb begin
    next_s = s;
    next_s.sck_prev = syn.sck;
    next_s.ss_prev = syn.ss;
    next_s.select_level = syn.ss ^ s.cfg[`SPF_CFG_POL];

    // register reads; a read of receive data empties the holding register
    next_s.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SPF_ADDR_DATA: begin
          next_s.rdata = s.rxd;
          next_s.rx_holding_full = 1'b0;
        end
        `SPF_ADDR_CMD: next_s.rdata = {6'h00, s.eof_flag, s.sel_val};
        `SPF_ADDR_CTL: next_s.rdata = {5'h00, s.rgc, s.mst, s.en};
        `SPF_ADDR_CFG: next_s.rdata = s.cfg;
        `SPF_ADDR_FLAGS: next_s.rdata = flags_rd;
        default: next_s.rdata = 8'h00;
      endcase
    end

    // write one to clear; engine sets below override so no event is lost
    if (reg_wr && (reg_addr == `SPF_ADDR_FLAGS)) begin
      if (reg_wdata[`SPF_FLG_TX_UNDERRUN]) next_s.tx_underrun = 1'b0;
      if (reg_wdata[`SPF_FLG_COLLISION]) next_s.col = 1'b0;
      if (reg_wdata[`SPF_FLG_ABORT]) next_s.slave_abort = 1'b0;
      if (reg_wdata[`SPF_FLG_RX_OVERRUN]) next_s.rx_overrun = 1'b0;
    end

    // master engine, paced by the half period ticker
    if (s.en && s.mst) begin
      // another master driving our input select to its active level is a mode fault
      if (!s.cfg[`SPF_CFG_DIR] && ss_act && !is_loop) begin
        next_s.col = 1'b1;
        next_s.fsm = SPF_IDLE;
        next_s.sck = 1'b0;
      end else begin
        unique case (s.fsm)
          SPF_IDLE: begin
            next_s.sck = 1'b0;
            if (s.tx_full) begin
              next_s.shreg = txalign;
              next_s.tx_full = 1'b0;
              next_s.eof_cur = s.tx_eof;
              next_s.bitcnt = len;
              next_s.lead = 1'b0;
              next_s.fsm = SPF_LEAD;
              if (is_i2s) begin
                next_s.pins.ss_o = sel_pin(s.sel_val, s.cfg[`SPF_CFG_POL]);
              end
            end
          end
          SPF_LEAD: begin
            // one clock period of setup; the I2S clock already runs here
            if (tick) begin
              if (is_i2s) next_s.sck = ~s.sck;
              next_s.lead = 1'b1;
              if (s.lead) begin
                next_s.fsm = SPF_XFER;
                next_s.lead = 1'b0;
              end
            end
          end
          SPF_XFER: begin
            if (tick && !s.sck) begin
              next_s.sck = 1'b1;
              next_s.samp = sin;
            end else if (tick) begin
              next_s.sck = 1'b0;
              next_s.shreg = shifted;
              next_s.bitcnt = s.bitcnt - 4'h1;
              // next frame's select goes out one period before its data
              if (is_i2s && (s.bitcnt == 4'h2) && s.tx_full) begin
                next_s.pins.ss_o = sel_pin(s.sel_val, s.cfg[`SPF_CFG_POL]);
              end
              if (s.bitcnt == 4'h1) begin
                if (s.rx_holding_full) begin
                  next_s.rx_overrun = 1'b1;
                end else begin
                  next_s.rxd = shifted & rmask;
                  next_s.rx_holding_full = 1'b1;
                end
                if (s.tx_full) begin
                  // back to back while data keeps coming
                  next_s.shreg = txalign;
                  next_s.tx_full = 1'b0;
                  next_s.eof_cur = s.tx_eof;
                  next_s.bitcnt = len;
                end else begin
                  next_s.fsm = SPF_IDLE;
                  if (is_spi && s.eof_cur) next_s.sel_val = 1'b0;
                end
              end
            end
          end
          default: next_s.fsm = SPF_IDLE;
        endcase
      end
    end

    // slave engine, driven by edges of the synchronised clock pin
    if (s.en && !s.mst) begin
      next_s.sck = 1'b0;
      unique case (s.fsm)
        SPF_IDLE: begin
          if (is_i2s ? ss_edge : ss_act) begin
            next_s.fsm = SPF_LEAD;
            next_s.bitcnt = len;
            next_s.loaded = s.tx_full;
            if (s.tx_full) begin
              next_s.shreg = txalign;
              next_s.tx_full = 1'b0;
            end
          end
        end
        SPF_LEAD: begin
          if (!s.loaded && s.tx_full) begin
            next_s.shreg = txalign;
            next_s.tx_full = 1'b0;
            next_s.loaded = 1'b1;
          end
          if (!is_i2s && !ss_act) begin
            next_s.fsm = SPF_IDLE;
          end else if (is_i2s ? sck_fall : sck_rise) begin
            next_s.fsm = SPF_XFER;
            if (!is_i2s) next_s.samp = sin;
            if (!s.loaded && !s.tx_full) begin
              next_s.tx_underrun = 1'b1;
              next_s.shreg = 8'hff;
            end
          end
        end
        SPF_XFER: begin
          if (is_i2s && ss_edge) next_s.pend = 1'b1;
          if (!is_i2s && !ss_act) begin
            next_s.slave_abort = 1'b1;
            next_s.fsm = SPF_IDLE;
          end else if (sck_rise) begin
            next_s.samp = sin;
          end else if (sck_fall) begin
            next_s.shreg = shifted;
            next_s.bitcnt = s.bitcnt - 4'h1;
            if (s.bitcnt == 4'h1) begin
              if (s.rx_holding_full) begin
                next_s.rx_overrun = 1'b1;
              end else begin
                next_s.rxd = shifted & rmask;
                next_s.rx_holding_full = 1'b1;
              end
              if (is_i2s && (s.pend || ss_edge)) begin
                // select changed during this character or on its last bit: next frame follows
                next_s.pend = 1'b0;
                next_s.bitcnt = len;
                if (s.tx_full) begin
                  next_s.shreg = txalign;
                  next_s.tx_full = 1'b0;
                end else begin
                  next_s.tx_underrun = 1'b1;
                  next_s.shreg = 8'hff;
                end
              end else begin
                next_s.fsm = SPF_IDLE;
                next_s.pend = 1'b0;
              end
            end
          end
        end
        default: next_s.fsm = SPF_IDLE;
      endcase
      // clock monitor; only edges restart it, so a stalled master is caught
      next_s.tmo = 10'h000;
      if (s.rgc && (s.fsm != SPF_IDLE) && !sck_rise && !sck_fall) begin
        next_s.tmo = s.tmo + 10'h001;
        if (s.tmo == 10'(`SPF_SCK_TMO_CYC - 1)) begin
          next_s.slave_abort = 1'b1;
          next_s.fsm = SPF_IDLE;
          next_s.tmo = 10'h000;
        end
      end
    end

    // disabled: status back to reset, engine parked
    if (!s.en) begin
      next_s.tx_underrun = 1'b0;
      next_s.col = 1'b0;
      next_s.slave_abort = 1'b0;
      next_s.rx_overrun = 1'b0;
      next_s.rx_holding_full = 1'b0;
      next_s.select_level = 1'b1;
      next_s.tx_full = 1'b0;
      next_s.fsm = SPF_IDLE;
      next_s.sck = 1'b0;
      next_s.pend = 1'b0;
      next_s.tmo = 10'h000;
    end

    // configuration and data writes; a data write fills the holding register
    if (reg_wr) begin
      case (reg_addr)
        `SPF_ADDR_DATA: begin
          next_s.txd = reg_wdata;
          next_s.tx_full = 1'b1;
          next_s.tx_eof = s.eof_flag;
        end
        `SPF_ADDR_CMD: begin
          next_s.sel_val = reg_wdata[`SPF_CMD_SELV];
          next_s.eof_flag = reg_wdata[`SPF_CMD_EOF];
        end
        `SPF_ADDR_CTL: begin
          next_s.en = reg_wdata[`SPF_CTL_EN];
          next_s.mst = reg_wdata[`SPF_CTL_MST];
          next_s.rgc = reg_wdata[`SPF_CTL_RGC];
        end
        `SPF_ADDR_CFG: next_s.cfg = reg_wdata;
        default: ;
      endcase
    end

    // pin drive, computed from the next state so pins match the engine
    next_s.pins.sck_o = next_s.sck && mo_en;
    next_s.pins.sck_oe = mo_en;
    next_s.pins.mosi_o = mo_en && next_s.shreg[7];
    next_s.pins.mosi_oe = mo_en;
    next_s.pins.miso_oe = s.en && !s.mst && ss_act;
    next_s.pins.miso_o = is_loop ? syn.mosi : next_s.shreg[7];
    next_s.pins.ss_oe = s.en && s.cfg[`SPF_CFG_DIR] && !(is_loop && s.mst);
    if (!is_i2s) begin
      next_s.pins.ss_o = sel_pin(next_s.sel_val, s.cfg[`SPF_CFG_POL]);
    end
  end

  // single state register; synchronous reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
      s.select_level <= 1'b1;
      s.pins.ss_o <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign pin_out = s.pins;

endmodule : spf_top

`default_nettype wire

//--- pkg/spf_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and 8-bit registers at byte offsets
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// register byte addresses
`define SPF_ADDR_DATA 24'hffe260
`define SPF_ADDR_CMD 24'hffe261
`define SPF_ADDR_CTL 24'hffe262
`define SPF_ADDR_CFG 24'hffe263
`define SPF_ADDR_FLAGS 24'hffe264

// reset values
`define SPF_FLAGS_RST 8'h01
`define SPF_CFG_RST 8'h00
`define SPF_CTL_RST 8'h00
`define SPF_CMD_RST 8'h00

// framing config fields
`define SPF_CFG_FRAME_MSB 7
`define SPF_CFG_FRAME_LSB 5
`define SPF_CFG_LEN_MSB 4
`define SPF_CFG_LEN_LSB 2
`define SPF_CFG_DIR 1
`define SPF_CFG_POL 0

// transmit command fields
`define SPF_CMD_SELV 0
`define SPF_CMD_EOF 1

// control fields
`define SPF_CTL_EN 0
`define SPF_CTL_MST 1
`define SPF_CTL_RGC 2

// flag register fields
`define SPF_FLG_TX_EMPTY 7
`define SPF_FLG_TX_UNDERRUN 6
`define SPF_FLG_COLLISION 5
`define SPF_FLG_ABORT 4
`define SPF_FLG_RX_OVERRUN 3
`define SPF_FLG_RX_FULL 2
`define SPF_FLG_ACTIVE 1
`define SPF_FLG_SEL_LEVEL 0

// timing
`define SPF_CLK_NS 10
`define SPF_SCK_HALF_NS 40
`define SPF_SCK_HALF_CYC (`SPF_SCK_HALF_NS / `SPF_CLK_NS)
`define SPF_SCK_TMO_NS 10000
`define SPF_SCK_TMO_CYC (`SPF_SCK_TMO_NS / `SPF_CLK_NS)

`endif

//--- pkg/spf_pkg.sv
// types shared by the serial port framing and status block
// assumes the register constants come from spf_regs.svh
package spf_pkg;

  // transfer engine states
  typedef enum logic [1:0] {
    SPF_IDLE = 2'b00,
    SPF_LEAD = 2'b01,
    SPF_XFER = 2'b10
  } spf_state_e;

  // framing_select codes
  typedef enum logic [2:0] {
    SPF_FR_SPI = 3'b000,
    SPF_FR_LOOP = 3'b001,
    SPF_FR_I2S = 3'b010
  } spf_frame_e;

  // pin levels seen from outside
  typedef struct packed {
    logic sck;
    logic ss;
    logic mosi;
    logic miso;
  } spf_pin_in_s;

  // pin drive values and enables
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic ss_o;
    logic ss_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spf_pin_out_s;

  // whole state of the top module
  typedef struct packed {
    logic en;
    logic mst;
    logic rgc;
    logic [7:0] cfg;
    logic sel_val;
    logic eof_flag;
    logic [7:0] txd;
    logic tx_full;
    logic tx_eof;
    logic eof_cur;
    logic loaded;
    logic pend;
    logic lead;
    logic [7:0] rxd;
    logic tx_underrun;
    logic col;
    logic slave_abort;
    logic rx_overrun;
    logic rx_holding_full;
    logic select_level;
    spf_state_e fsm;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic samp;
    logic sck;
    logic sck_prev;
    logic ss_prev;
    logic [9:0] tmo;
    logic [7:0] rdata;
    spf_pin_out_s pins;
  } spf_state_s;

  // synchroniser state
  typedef struct packed {
    spf_pin_in_s meta;
    spf_pin_in_s stable;
  } spf_sync_s;

  // half period ticker state
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } spf_tick_s;

endpackage : spf_pkg

//--- design/spf_sync.sv
// two-stage synchroniser for the four serial pins
// assumes pins are asynchronous to clock; only the second stage is read
`timescale 1ns/1ns
`default_nettype none

module spf_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire spf_pkg::spf_pin_in_s raw,
  output var spf_pkg::spf_pin_in_s synced
);
  import spf_pkg::*;

  spf_sync_s s;
  spf_sync_s next_s;

  // meta stage feeds only the stable stage
  always_comb begin
    next_s = s;
    next_s.meta = raw;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.stable;

endmodule : spf_sync

`default_nettype wire

//--- design/spf_ticker.sv
// half serial clock period ticker for master mode
// assumes run is high for as long as the serial clock should toggle
`timescale 1ns/1ns
`default_nettype none
`include "spf_regs.svh"

module spf_ticker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  output logic tick
);
  import spf_pkg::*;

  spf_tick_s s;
  spf_tick_s next_s;

  // restart from zero so every frame sees a full first half period
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 3'h0;
    end else if (s.cnt == 3'(`SPF_SCK_HALF_CYC - 1)) begin
      next_s.cnt = 3'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : spf_ticker

`default_nettype wire

//--- dv/spf_chk.sv
// port checker for the framing and status block
// assumes it is bound to spf_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "spf_regs.svh"

module spf_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [23:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire spf_pkg::spf_pin_in_s pin_in,
  input wire spf_pkg::spf_pin_out_s pin_out
);
  import spf_pkg::*;
  logic [7:0] cfg_s;
  logic [2:0] ctl_s;
  logic sel_s;
  logic [1:0] gap;
  // shadow of written settings; gap lets registered pins catch up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_s <= `SPF_CFG_RST;
      ctl_s <= 3'h0;
      sel_s <= 1'b0;
      gap <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `SPF_ADDR_CFG) cfg_s <= reg_wdata;
      if (reg_wr && reg_addr == `SPF_ADDR_CTL) ctl_s <= reg_wdata[2:0];
      if (reg_wr && reg_addr == `SPF_ADDR_CMD) sel_s <= reg_wdata[`SPF_CMD_SELV];
      gap <= reg_wr ? 2'h0 : (gap == 2'h3 ? gap : gap + 2'h1);
    end
  end
  wire logic settled = gap == 2'h3;
  wire logic spi_m = ctl_s[0] && ctl_s[1] && cfg_s[7:5] == 3'b000;
  wire logic mapped = reg_addr >= `SPF_ADDR_DATA && reg_addr <= `SPF_ADDR_FLAGS;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // select never asserted once software dropped it; hardware may drop it early
  property p_ss_idle;
    settled && spi_m && cfg_s[1] && !sel_s |-> pin_out.ss_oe && pin_out.ss_o == !cfg_s[0];
  endproperty
  a_ss_idle: assert property (p_ss_idle) else $error("select level wrong");
  property p_ss_dir;
    settled && spi_m |-> pin_out.ss_oe == cfg_s[1];
  endproperty
  a_ss_dir: assert property (p_ss_dir) else $error("select direction wrong");
  property p_loop_off;
    settled && ctl_s[0] && ctl_s[1] && cfg_s[7:5] == 3'b001 |-> !pin_out.sck_oe && !pin_out.mosi_oe;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loopback drives pins");
  property p_sck_half;
    spi_m && pin_out.sck_oe && $changed(pin_out.sck_o) |=> $stable(pin_out.sck_o) [*3];
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock too fast");
  property p_mosi_hold;
    spi_m && pin_out.sck_oe && $rose(pin_out.sck_o) |-> $stable(pin_out.mosi_o);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved on rising");
  property p_flags_off;
    reg_rd && reg_addr == `SPF_ADDR_FLAGS && !ctl_s[0] && !$past(ctl_s[0])
      |=> reg_rdata == `SPF_FLAGS_RST;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("flags not reset");
  property p_rdata_zero;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data not idle");
  property p_unmapped;
    reg_rd && !mapped |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_ss_low: cover property (spi_m && $fell(pin_out.ss_o));
  c_sck: cover property (spi_m && $rose(pin_out.sck_o));
  c_loop: cover property (settled && ctl_s[1] && cfg_s[7:5] == 3'b001);
endmodule : spf_chk
`default_nettype wire

//--- dv/spf_remote.sv
// behavioural remote spi slave, mode 0, msb first, returns a rotating byte
// assumes select active low and a clock that stands still between frames
`timescale 1ns/1ns
`default_nettype none

module spf_remote (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] tx = 8'h3c;
  initial miso = 1'b0;
  initial rx = 8'h00;
  // first bit ready before the first rising edge
  always @(negedge ss_n) miso = tx[7];
  // released line shows the inverse, never a stale value
  always @(posedge ss_n) miso = ~miso;
  // sample on rising
  always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
  // shift on falling; rotation repeats the byte every eight clocks
  always @(negedge sck) begin
    if (!ss_n) begin
      tx = {tx[6:0], tx[7]};
      miso = tx[7];
    end
  end
endmodule : spf_remote
`default_nettype wire

//--- dv/spf_tb_top.sv
// self-checking bench for spf_top with a remote slave on the pins
// assumes pkg/ on the include path; select pulled up, clock and data pulled down
`timescale 1ns/1ns
`default_nettype none
`include "spf_regs.svh"

module spf_tb_top;
  import spf_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [23:0] reg_addr = 24'h000000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tb_ss = 1'b1;
  logic tb_sck = 1'b0;
  logic p_miso;
  logic [7:0] p_rx;
  logic sck_q = 1'b0;
  logic [7:0] rise_cnt = 8'h00;
  logic [7:0] v;
  logic [7:0] base;
  logic [2:0] codes [7] = '{3'b000, 3'b001, 3'b010, 3'b101, 3'b100, 3'b110, 3'b111};
  int nbits [7] = '{8, 1, 2, 3, 4, 6, 7};
  int error_cnt = 0;
  int total_checks = 0;
  spf_pin_in_s pin_in;
  spf_pin_out_s pin_out;

  always #5 clock = ~clock;
  // wire levels from every party's enable
  assign pin_in = {pin_out.sck_oe ? pin_out.sck_o : tb_sck, pin_out.ss_oe ? pin_out.ss_o : tb_ss,
    pin_out.mosi_oe ? pin_out.mosi_o : 1'b0, pin_out.miso_oe ? pin_out.miso_o : p_miso};
  // counts driven serial clock rising edges
  always @(posedge clock) begin
    sck_q <= pin_out.sck_o;
    if (pin_out.sck_oe && pin_out.sck_o && !sck_q) rise_cnt <= rise_cnt + 8'h01;
  end

  spf_top spf_top_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out));
  spf_remote spf_remote_i (.sck(pin_in.sck), .ss_n(pin_in.ss), .mosi(pin_in.mosi),
    .miso(p_miso), .rx(p_rx));

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask : rd
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // polls a flag bit under a bounded count
  task automatic wait_flag(input int b, input logic val);
    int n;
    logic [7:0] f;
    n = 0;
    rd(`SPF_ADDR_FLAGS, f);
    while (f[b] !== val && n < 300) begin
      rd(`SPF_ADDR_FLAGS, f);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      $display("[ERR] flag_%0d expected %b seen %b", b, val, f[b]);
    end
  endtask : wait_flag
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`SPF_ADDR_FLAGS, v); check("flags_rst", v, `SPF_FLAGS_RST);
    rd(`SPF_ADDR_CFG, v); check("cfg_rst", v, `SPF_CFG_RST);
    rd(24'hffe2a0, v); check("unmapped", v, 8'h00);
    $display("test reset done");
    wr(`SPF_ADDR_CFG, 8'h02);
    wr(`SPF_ADDR_CTL, 8'h03);
    rd(`SPF_ADDR_FLAGS, v); check("flags_en", v, 8'h81);
    check("ss_idle", {7'h00, pin_out.ss_o}, 8'h01);
    wr(`SPF_ADDR_CMD, 8'h01);
    repeat (3) @(posedge clock);
    check("ss_assert", {7'h00, pin_out.ss_o}, 8'h00);
    wr(`SPF_ADDR_DATA, 8'ha5);
    wait_flag(7, 1'b1);
    wr(`SPF_ADDR_CMD, 8'h03);
    wr(`SPF_ADDR_DATA, 8'h5a);
    rd(`SPF_ADDR_FLAGS, v); check("tx_full_active", {6'h00, v[7], v[1]}, 8'h01);
    wait_flag(2, 1'b1);
    wait_flag(1, 1'b0);
    rd(`SPF_ADDR_FLAGS, v); check("flags_ovr", v, 8'h8d);
    check("remote_rx", p_rx, 8'h5a);
    check("ss_eof", {7'h00, pin_out.ss_o}, 8'h01);
    rd(`SPF_ADDR_DATA, v); check("rx_data", v, 8'h3c);
    wr(`SPF_ADDR_FLAGS, 8'h00);
    rd(`SPF_ADDR_FLAGS, v); check("w0_keep", v, 8'h89);
    wr(`SPF_ADDR_FLAGS, 8'h08);
    rd(`SPF_ADDR_FLAGS, v); check("w1_clear", v, 8'h81);
    $display("test spi frame done");
    for (int i = 0; i < 7; i++) begin
      wr(`SPF_ADDR_CFG, {3'b000, codes[i], 2'b10});
      wr(`SPF_ADDR_CMD, 8'h03);
      base = rise_cnt;
      wr(`SPF_ADDR_DATA, 8'hff);
      wait_flag(2, 1'b1);
      rd(`SPF_ADDR_DATA, v);
      wait_flag(1, 1'b0);
      check("sck_rises", rise_cnt - base, nbits[i][7:0]);
    end
    $display("test char length done");
    wr(`SPF_ADDR_CFG, 8'h03);
    wr(`SPF_ADDR_CMD, 8'h01);
    repeat (3) @(posedge clock);
    check("ss_high_act", {7'h00, pin_out.ss_o}, 8'h01);
    wr(`SPF_ADDR_CMD, 8'h00);
    repeat (3) @(posedge clock);
    check("ss_high_idle", {7'h00, pin_out.ss_o}, 8'h00);
    $display("test polarity done");
    wr(`SPF_ADDR_CFG, 8'h22);
    wr(`SPF_ADDR_DATA, 8'h96);
    check("loop_oe", {6'h00, pin_out.sck_oe, pin_out.mosi_oe}, 8'h00);
    wait_flag(2, 1'b1);
    rd(`SPF_ADDR_DATA, v); check("loop_data", v, 8'h96);
    wait_flag(1, 1'b0);
    $display("test loopback done");
    wr(`SPF_ADDR_CFG, 8'h00);
    tb_ss <= 1'b0;
    wr(`SPF_ADDR_DATA, 8'h11);
    wait_flag(5, 1'b1);
    rd(`SPF_ADDR_FLAGS, v); check("collision", {7'h00, v[5]}, 8'h01);
    tb_ss <= 1'b1;
    // synchronised select must settle first, or the collision set wins the clear
    repeat (3) @(posedge clock);
    wr(`SPF_ADDR_FLAGS, 8'h20);
    rd(`SPF_ADDR_FLAGS, v); check("col_clear", {7'h00, v[5]}, 8'h00);
    wr(`SPF_ADDR_CTL, 8'h00);
    rd(`SPF_ADDR_FLAGS, v); check("flags_off", v, `SPF_FLAGS_RST);
    $display("test collision and disable done");
    // slave: one pin clock bit with no data loaded, then select dropped early
    wr(`SPF_ADDR_CFG, 8'h00);
    wr(`SPF_ADDR_CTL, 8'h01);
    tb_ss <= 1'b0;
    repeat (8) @(posedge clock);
    tb_sck <= 1'b1;
    repeat (6) @(posedge clock);
    tb_sck <= 1'b0;
    repeat (6) @(posedge clock);
    tb_ss <= 1'b1;
    repeat (6) @(posedge clock);
    rd(`SPF_ADDR_FLAGS, v); check("slave_abort", {6'h00, v[6], v[4]}, 8'h03);
    wr(`SPF_ADDR_CTL, 8'h00);
    rd(`SPF_ADDR_FLAGS, v); check("abort_off", v, `SPF_FLAGS_RST);
    // loopback slave with a stalled clock: echo path enabled, monitor aborts
    wr(`SPF_ADDR_CFG, 8'h20);
    wr(`SPF_ADDR_CTL, 8'h05);
    tb_ss <= 1'b0;
    repeat (1100) @(posedge clock);
    check("echo", {6'h00, pin_out.miso_oe, pin_out.miso_o}, 8'h02);
    rd(`SPF_ADDR_FLAGS, v); check("abort_tmo", {7'h00, v[4]}, 8'h01);
    tb_ss <= 1'b1;
    $display("test slave abort done");
    test_done();
  end

  // run takes a few thousand cycles; cut a hang well after that
  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    test_done();
  end
endmodule : spf_tb_top

bind spf_top spf_chk spf_chk_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out));
`default_nettype wire
